/* File: src/rtc_pkg.sv */
/*
 Constants, types and helpers of the clock/calendar register window block.
 Assumes a 32-bit AHB-Lite bus with the byte map decoded from haddr[7:0].
*/
package rtc_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_TIME = 8'h04;
   localparam logic [7:0] OFF_ALARM = 8'h08;
   localparam logic [7:0] OFF_ALCFG = 8'h0c;
   localparam logic [7:0] OFF_PWC = 8'h10;
   localparam logic [7:0] OFF_KEY = 8'h14;
   // ----------------------------------------
   // Field positions and fixed values
   // ----------------------------------------
   localparam int PTR_LSB = 8;
   localparam int OE_BIT = 10;
   localparam int SRC_LSB = 10;
   localparam int UNLOCK_BIT = 13;
   localparam int EN_BIT = 15;
   localparam logic [1:0] PTR_MIN = 2'h0;
   localparam logic [1:0] PTR_MAX = 2'h3;
   localparam logic [7:0] KEY_FIRST_VAL = 8'h55;
   localparam logic [7:0] KEY_SECOND_VAL = 8'haa;
   localparam logic [2:0] SIZE_BYTE = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [15:0] REG16_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      KEY_IDLE = 2'b00,
      KEY_FIRST = 2'b01,
      KEY_ARMED = 2'b11
   } key_state_t;
   typedef struct packed {
      logic enable;
      logic unlock;
      logic out_en;
      logic [1:0] ptr;
      logic [7:0] trim;
   } calib_cfg_t;
   localparam calib_cfg_t CFG_RESET = '0;
   typedef struct packed {
      logic run;
      logic out_en;
      logic [1:0] source;
      logic [7:0] trim;
      logic [7:0] settle;
      logic [7:0] sample;
   } rtc_ctrl_t;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [1:0] ptr_dec(input logic [1:0] p);
      return (p == PTR_MIN) ? PTR_MIN : p - 2'h1;
   endfunction
   function automatic logic [1:0] byte_lanes(input logic [2:0] size, input logic [1:0] a);
      if (size == SIZE_BYTE) begin
         return {a == 2'h1, a == 2'h0};
      end
      return {~a[1], ~a[1]};
   endfunction
endpackage

/* File: src/rtc_window_regs.sv */
/*
 AHB-Lite register slave for the clock/calendar control and window registers.
 Assumes half_tick and rollover_pending come from timekeeping logic on hclk.
*/
`timescale 1ns/100ps
module rtc_window_regs (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [1:0] hresp,
   output logic [31:0] hrdata,
   input wire logic half_tick,
   input wire logic rollover_pending,
   output rtc_pkg::rtc_ctrl_t ctrl
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   rtc_pkg::calib_cfg_t cfg;
   rtc_pkg::key_state_t key_state;
   rtc_pkg::key_state_t next_key_state;
   logic [7:0] time_bytes [0:7];
   logic [7:0] alarm_bytes [0:7];
   logic [15:0] alcfg;
   logic [15:0] pwc;
   logic ripple;
   logic half;
   logic wr_pend;
   logic [7:0] wr_off;
   logic [1:0] wr_lanes;
   logic rd_pend;
   logic [7:0] rd_off_q;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire addr_ok = hsel & htrans[1] & hready & clk_en;
   // A read right behind a write waits one cycle so it sees the write
   wire rd_now = addr_ok & ~hwrite & ~wr_pend;
   wire rd_defer = addr_ok & ~hwrite & wr_pend;
   wire rd_fire = (rd_now | rd_pend) & clk_en;
   wire [7:0] rd_off = rd_pend ? rd_off_q : {haddr[7:2], 2'h0};
   wire wr_fire = wr_pend & clk_en;
   wire cfg_wr = wr_fire & (wr_off == rtc_pkg::OFF_CFG);
   wire cfg_wr_hi = cfg_wr & wr_lanes[1];
   wire cfg_wr_lo = cfg_wr & wr_lanes[0];
   wire time_wr = wr_fire & (wr_off == rtc_pkg::OFF_TIME) & cfg.unlock;
   wire time_hi_wr = time_wr & wr_lanes[1];
   wire time_lo_wr = time_wr & wr_lanes[0];
   wire alarm_wr = wr_fire & (wr_off == rtc_pkg::OFF_ALARM);
   wire alarm_hi_wr = alarm_wr & wr_lanes[1];
   wire alarm_lo_wr = alarm_wr & wr_lanes[0];
   wire alcfg_wr = wr_fire & (wr_off == rtc_pkg::OFF_ALCFG);
   wire pwc_wr = wr_fire & (wr_off == rtc_pkg::OFF_PWC);
   wire key_wr = wr_fire & (wr_off == rtc_pkg::OFF_KEY) & wr_lanes[0];
   wire time_rd = rd_fire & (rd_off == rtc_pkg::OFF_TIME);
   wire alarm_rd = rd_fire & (rd_off == rtc_pkg::OFF_ALARM);
   wire [7:0] wd_lo = hwdata[7:0];
   wire [7:0] wd_hi = hwdata[15:8];
   wire [1:0] alarm_ptr = alcfg[rtc_pkg::PTR_LSB +: 2];

   // ----------------------------------------
   // Window pointers
   // ----------------------------------------
   // Either byte of a read moves the pointer; writes only on the high byte
   wire time_step = time_rd | time_hi_wr;
   wire alarm_step = alarm_rd | alarm_hi_wr;
   wire [1:0] next_time_ptr = cfg_wr_hi ? wd_hi[1:0] :
      time_step ? rtc_pkg::ptr_dec(cfg.ptr) : cfg.ptr;
   wire [1:0] next_alarm_ptr = (alcfg_wr & wr_lanes[1]) ? wd_hi[1:0] :
      alarm_step ? rtc_pkg::ptr_dec(alarm_ptr) : alarm_ptr;

   // ----------------------------------------
   // Unlock key sequence
   // ----------------------------------------
   always_comb begin
      next_key_state = key_state;
      if (key_wr) begin
         unique case (key_state)
            rtc_pkg::KEY_FIRST: begin
               next_key_state = (wd_lo == rtc_pkg::KEY_SECOND_VAL) ?
                  rtc_pkg::KEY_ARMED : rtc_pkg::KEY_IDLE;
            end
            rtc_pkg::KEY_IDLE, rtc_pkg::KEY_ARMED: begin
               next_key_state = (wd_lo == rtc_pkg::KEY_FIRST_VAL) ?
                  rtc_pkg::KEY_FIRST : rtc_pkg::KEY_IDLE;
            end
            default: begin
               next_key_state = rtc_pkg::KEY_IDLE;
            end
         endcase
      end else if (wr_fire) begin
         next_key_state = rtc_pkg::KEY_IDLE;
      end
   end

   // ----------------------------------------
   // Config next value
   // ----------------------------------------
   wire set_unlock = wd_hi[rtc_pkg::UNLOCK_BIT - 8];
   wire next_unlock = cfg_wr_hi ?
      (set_unlock & (cfg.unlock | (key_state == rtc_pkg::KEY_ARMED))) : cfg.unlock;
   wire next_enable = (cfg_wr_hi & cfg.unlock) ? wd_hi[rtc_pkg::EN_BIT - 8] : cfg.enable;
   wire next_out_en = cfg_wr_hi ? wd_hi[rtc_pkg::OE_BIT - 8] : cfg.out_en;
   wire [7:0] next_trim = cfg_wr_lo ? wd_lo : cfg.trim;
   wire half_clear = time_lo_wr & (cfg.ptr == rtc_pkg::PTR_MIN);
   // Tick beats the clear so a boundary is never lost
   wire next_half = (half_clear ? 1'b0 : half) ^ (half_tick & cfg.enable);

   // ----------------------------------------
   // Window byte writes
   // ----------------------------------------
   wire [7:0] time_we;
   wire [7:0] alarm_we;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_we
         localparam logic [2:0] IDX = 3'(gi);
         // Time entry 7 has no counter behind it and stays zero
         assign time_we[gi] = (IDX != {rtc_pkg::PTR_MAX, 1'b1}) & (IDX[2:1] == cfg.ptr) &
            (IDX[0] ? time_hi_wr : time_lo_wr);
         assign alarm_we[gi] = (IDX[2:1] == alarm_ptr) & (IDX[0] ? alarm_hi_wr : alarm_lo_wr);
      end
   endgenerate

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   wire [15:0] cfg_word = {cfg.enable, 1'b0, cfg.unlock, ripple, half, cfg.out_en,
      cfg.ptr, cfg.trim};
   wire [15:0] time_word = {time_bytes[{cfg.ptr, 1'b1}], time_bytes[{cfg.ptr, 1'b0}]};
   wire [15:0] alarm_word = {alarm_bytes[{alarm_ptr, 1'b1}],
      alarm_bytes[{alarm_ptr, 1'b0}]};
   wire [15:0] rd_word = (rd_off == rtc_pkg::OFF_CFG) ? cfg_word :
      (rd_off == rtc_pkg::OFF_TIME) ? time_word :
      (rd_off == rtc_pkg::OFF_ALARM) ? alarm_word :
      (rd_off == rtc_pkg::OFF_ALCFG) ? alcfg :
      (rd_off == rtc_pkg::OFF_PWC) ? pwc : rtc_pkg::REG16_RESET;

   // ----------------------------------------
   // Bus slave flops
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= rtc_pkg::RESP_OKAY;
         hrdata <= {16'h0000, rtc_pkg::REG16_RESET};
         wr_pend <= 1'b0;
         wr_off <= rtc_pkg::OFF_CFG;
         wr_lanes <= 2'h0;
         rd_pend <= 1'b0;
         rd_off_q <= rtc_pkg::OFF_CFG;
      end else if (clk_en) begin
         hreadyout <= ~rd_defer;
         wr_pend <= addr_ok & hwrite;
         if (addr_ok) begin
            wr_off <= {haddr[7:2], 2'h0};
            wr_lanes <= rtc_pkg::byte_lanes(hsize, haddr[1:0]);
            rd_off_q <= {haddr[7:2], 2'h0};
         end
         rd_pend <= rd_defer;
         if (rd_fire) begin
            hrdata <= {16'h0000, rd_word};
         end
      end
   end

   // ----------------------------------------
   // Control and window storage
   // ----------------------------------------
   // The only reset is hresetn, which is the power-on reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg <= rtc_pkg::CFG_RESET;
         key_state <= rtc_pkg::KEY_IDLE;
         alcfg <= rtc_pkg::REG16_RESET;
         pwc <= rtc_pkg::REG16_RESET;
         ripple <= 1'b0;
         half <= 1'b0;
      end else if (clk_en) begin
         cfg.ptr <= next_time_ptr;
         cfg.unlock <= next_unlock;
         cfg.enable <= next_enable;
         cfg.out_en <= next_out_en;
         cfg.trim <= next_trim;
         key_state <= next_key_state;
         if (alcfg_wr & wr_lanes[0]) begin
            alcfg[7:0] <= wd_lo;
         end
         if (alcfg_wr & wr_lanes[1]) begin
            alcfg[15:10] <= wd_hi[7:2];
         end
         alcfg[rtc_pkg::PTR_LSB +: 2] <= next_alarm_ptr;
         if (pwc_wr & wr_lanes[0]) begin
            pwc[7:0] <= wd_lo;
         end
         if (pwc_wr & wr_lanes[1]) begin
            pwc[15:8] <= wd_hi;
         end
         ripple <= cfg.enable & rollover_pending;
         half <= next_half;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 8; i++) begin
            time_bytes[i] <= rtc_pkg::BYTE_RESET;
            alarm_bytes[i] <= rtc_pkg::BYTE_RESET;
         end
      end else if (clk_en) begin
         for (int i = 0; i < 8; i++) begin
            if (time_we[i]) begin
               time_bytes[i] <= i[0] ? wd_hi : wd_lo;
            end
            if (alarm_we[i]) begin
               alarm_bytes[i] <= i[0] ? wd_hi : wd_lo;
            end
         end
      end
   end

   // ----------------------------------------
   // Control outputs
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= '0;
      end else if (clk_en) begin
         ctrl.run <= cfg.enable;
         ctrl.out_en <= cfg.out_en;
         ctrl.source <= pwc[rtc_pkg::SRC_LSB +: 2];
         ctrl.trim <= cfg.trim;
         ctrl.settle <= alarm_bytes[{rtc_pkg::PTR_MAX, 1'b1}];
         ctrl.sample <= alarm_bytes[{rtc_pkg::PTR_MAX, 1'b0}];
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_time_read;
      time_rd & ~cfg_wr_hi;
   endsequence
   sequence s_alarm_hi_write;
      alarm_hi_wr & ~alcfg_wr;
   endsequence
   // Second key byte landing on a machine that already saw the first
   sequence s_key_done;
      key_wr & (wd_lo == rtc_pkg::KEY_SECOND_VAL) & (key_state == rtc_pkg::KEY_FIRST);
   endsequence

   property p_time_read_dec;
      s_time_read |=> cfg.ptr == rtc_pkg::ptr_dec($past(cfg.ptr));
   endproperty
   a_time_read_dec: assert property (p_time_read_dec) else $error("time ptr not stepped");

   property p_alarm_write_dec;
      s_alarm_hi_write |=> alarm_ptr == rtc_pkg::ptr_dec($past(alarm_ptr));
   endproperty
   a_alarm_write_dec: assert property (p_alarm_write_dec) else $error("alarm ptr not stepped");

   property p_low_write_hold;
      (time_lo_wr & ~time_hi_wr & ~cfg_wr_hi & ~time_rd) |=> $stable(cfg.ptr);
   endproperty
   a_low_write_hold: assert property (p_low_write_hold) else $error("low write moved ptr");

   property p_zero_sticks;
      (cfg.ptr == rtc_pkg::PTR_MIN) & ~cfg_wr_hi |=> cfg.ptr == rtc_pkg::PTR_MIN;
   endproperty
   a_zero_sticks: assert property (p_zero_sticks) else $error("ptr left zero");

   property p_locked_time;
      (wr_fire & (wr_off == rtc_pkg::OFF_TIME) & ~cfg.unlock) |=>
         $stable(time_bytes[0]) & $stable(cfg.ptr);
   endproperty
   a_locked_time: assert property (p_locked_time) else $error("locked write took");

   property p_enable_guard;
      (cfg_wr_hi & ~cfg.unlock) |=> $stable(cfg.enable);
   endproperty
   a_enable_guard: assert property (p_enable_guard) else $error("enable changed locked");

   property p_unlock_key;
      $rose(cfg.unlock) |-> $past(key_state) == rtc_pkg::KEY_ARMED;
   endproperty
   a_unlock_key: assert property (p_unlock_key) else $error("unlock without key");

   property p_key_arms;
      s_key_done |=> key_state == rtc_pkg::KEY_ARMED;
   endproperty
   a_key_arms: assert property (p_key_arms) else $error("key did not arm");

   property p_half_clear;
      (half_clear & ~half_tick) |=> ~half ##1 (~half | $past(half_tick & cfg.enable));
   endproperty
   a_half_clear: assert property (p_half_clear) else $error("half flag not cleared");

   property p_bit14_zero;
      (rd_fire & (rd_off == rtc_pkg::OFF_CFG)) |=> ~hrdata[14];
   endproperty
   a_bit14_zero: assert property (p_bit14_zero) else $error("bit 14 read as one");
endmodule

/* File: verification/rtc_window_regs_bench.sv */
/*
 Self-checking bench for the clock/calendar register window slave.
 Assumes rtc_pkg and rtc_window_regs are compiled first; bench is the only bus master.
*/
`timescale 1ns/100ps
module rtc_window_regs_bench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic clk_en = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout;
   logic [1:0] hresp;
   logic [31:0] hrdata;
   logic half_tick = 1'b0;
   logic rollover_pending = 1'b0;
   rtc_pkg::rtc_ctrl_t ctrl;
   logic [31:0] rd;
   int mismatches = 0;
   int n_tests = 0;

   always #20 hclk = ~hclk;

   rtc_window_regs rtc_window_regs_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .half_tick(half_tick), .rollover_pending(rollover_pending),
      .ctrl(ctrl));

   // ----------------------------------------
   // Bus and compare tasks
   // ----------------------------------------
   task automatic conclude();
      $display("Counts: %0d compares, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // Bounded wait; a stuck slave ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 16) begin
            chk(32'(hreadyout), 32'h0000_0001);
            conclude();
         end
         @(posedge hclk);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [2:0] sz,
                       input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      hsize <= sz;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      chk(32'(hresp), 32'(rtc_pkg::RESP_OKAY));
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      xfer(1'b1, a, 3'h2, {16'h0000, d});
   endtask

   task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
      xfer(1'b0, a, 3'h2, 32'h0000_0000);
      chk(rd, {16'h0000, exp});
   endtask

   task automatic rd_seq(input logic [7:0] a, input logic [79:0] ex);
      for (int i = 0; i < 5; i++) begin
         rdc(a, ex[16*(4-i) +: 16]);
      end
   endtask

   task automatic unlock(input logic [15:0] cfg);
      wr(rtc_pkg::OFF_KEY, 16'h0055);
      wr(rtc_pkg::OFF_KEY, 16'h00aa);
      wr(rtc_pkg::OFF_CFG, cfg);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rdc(rtc_pkg::OFF_CFG, 16'h0000);
      chk(32'(ctrl), 32'h0000_0000);
      wr(8'h20, 16'hffff);
      rdc(8'h20, 16'h0000);
      $display("test reset done");
   endtask

   task automatic t_lock();
      wr(rtc_pkg::OFF_CFG, 16'h2000);
      rdc(rtc_pkg::OFF_CFG, 16'h0000);
      wr(rtc_pkg::OFF_KEY, 16'h0055);
      wr(rtc_pkg::OFF_KEY, 16'h00aa);
      wr(rtc_pkg::OFF_ALCFG, 16'h0000);
      wr(rtc_pkg::OFF_CFG, 16'h2000);
      rdc(rtc_pkg::OFF_CFG, 16'h0000);
      wr(rtc_pkg::OFF_CFG, 16'h8000);
      rdc(rtc_pkg::OFF_CFG, 16'h0000);
      unlock(16'he45a);
      rdc(rtc_pkg::OFF_CFG, 16'h245a);
      wr(rtc_pkg::OFF_CFG, 16'he45a);
      rdc(rtc_pkg::OFF_CFG, 16'ha45a);
      tick(3);
      chk(32'({ctrl.run, ctrl.out_en, ctrl.trim}), 32'h0000_035a);
      $display("test lock done");
   endtask

   task automatic t_flags();
      half_tick <= 1'b1;
      tick(1);
      half_tick <= 1'b0;
      rdc(rtc_pkg::OFF_CFG, 16'hac5a);
      clk_en <= 1'b0;
      half_tick <= 1'b1;
      tick(1);
      half_tick <= 1'b0;
      clk_en <= 1'b1;
      rdc(rtc_pkg::OFF_CFG, 16'hac5a);
      rollover_pending <= 1'b1;
      tick(2);
      rdc(rtc_pkg::OFF_CFG, 16'hbc5a);
      rdc(rtc_pkg::OFF_CFG, 16'hbc5a);
      rollover_pending <= 1'b0;
      tick(2);
      wr(rtc_pkg::OFF_TIME, 16'h0000);
      rdc(rtc_pkg::OFF_CFG, 16'ha45a);
      $display("test flags done");
   endtask

   task automatic t_time();
      unlock(16'ha35a);
      wr(rtc_pkg::OFF_TIME, 16'h1234);
      wr(rtc_pkg::OFF_TIME, 16'h5677);
      wr(rtc_pkg::OFF_TIME, 16'h9abc);
      wr(rtc_pkg::OFF_TIME, 16'hdef0);
      wr(rtc_pkg::OFF_TIME, 16'hde11);
      rdc(rtc_pkg::OFF_CFG, 16'ha05a);
      wr(rtc_pkg::OFF_CFG, 16'h835a);
      wr(rtc_pkg::OFF_TIME, 16'hffff);
      rdc(rtc_pkg::OFF_CFG, 16'h835a);
      rd_seq(rtc_pkg::OFF_TIME, 80'h0034_5677_9abc_de11_de11);
      rdc(rtc_pkg::OFF_CFG, 16'h805a);
      $display("test time done");
   endtask

   task automatic t_alarm();
      wr(rtc_pkg::OFF_ALCFG, 16'h0300);
      wr(rtc_pkg::OFF_ALARM, 16'ha1b2);
      wr(rtc_pkg::OFF_ALARM, 16'hc3d4);
      wr(rtc_pkg::OFF_ALARM, 16'he5f6);
      wr(rtc_pkg::OFF_ALARM, 16'h0718);
      rdc(rtc_pkg::OFF_ALCFG, 16'h0000);
      tick(3);
      chk(32'({ctrl.settle, ctrl.sample}), 32'h0000_a1b2);
      wr(rtc_pkg::OFF_ALCFG, 16'h0300);
      rd_seq(rtc_pkg::OFF_ALARM, 80'ha1b2_c3d4_e5f6_0718_0718);
      $display("test alarm done");
   endtask

   task automatic t_source();
      for (int s = 0; s < 4; s++) begin
         wr(rtc_pkg::OFF_PWC, 16'(s << 10));
         tick(3);
         chk(32'(ctrl.source), 32'(s));
      end
      $display("test source done");
   endtask

   // Mid-run reset stands in for power-on reset
   task automatic t_por();
      hresetn <= 1'b0;
      tick(2);
      hresetn <= 1'b1;
      tick(1);
      rdc(rtc_pkg::OFF_CFG, 16'h0000);
      chk(32'(ctrl), 32'h0000_0000);
      $display("test por done");
   endtask

   initial begin
      tick(2);
      hresetn <= 1'b1;
      tick(1);
      t_reset();
      t_lock();
      t_flags();
      t_time();
      t_alarm();
      t_source();
      t_por();
      conclude();
   end
endmodule
